// ### core/mcc_pkg.sv
// Constants, register map and carrier types of the metering channel control block.
// Assumes a 32-bit APB with each register on one aligned word.
package mcc_pkg;

    localparam int MCC_SAMPLE_W = 24;
    localparam int MCC_GAIN_HEAD = 6;
    localparam int MCC_OUT_W = MCC_SAMPLE_W + MCC_GAIN_HEAD;
    localparam int MCC_FIFO_DEPTH = 4;
    localparam int MCC_ADDR_W = 16;
    localparam logic [2:0] MCC_EXP_MAX = 3'h5;
    localparam int MCC_QUARTER_SHIFT = 2;

    // Register indices; the byte address is four times the index.
    localparam logic [13:0] MCC_IDX_ENABLE = 14'h2878;
    localparam logic [13:0] MCC_IDX_GAIN = 14'h2879;
    localparam logic [13:0] MCC_IDX_CTRL3 = 14'h287a;
    localparam logic [13:0] MCC_IDX_STATUS = 14'h28f0;

    localparam logic [7:0] MCC_ENABLE_RESET = 8'h00;
    localparam logic [7:0] MCC_GAIN_RESET = 8'h00;
    localparam logic MCC_QUARTER_RESET = 1'b0;

    // Field positions of metering_channel_enable.
    localparam int MCC_BIT_WRITE_BLOCK = 7;
    localparam int MCC_BIT_PHASE_COMP = 6;
    localparam int MCC_BIT_SWAP = 5;
    localparam int MCC_BIT_CALC_EN = 4;
    localparam int MCC_BIT_M_EN = 3;
    localparam int MCC_BIT_I2_EN = 2;
    localparam int MCC_BIT_I1_EN = 1;
    localparam int MCC_BIT_U_EN = 0;

    // Field positions of metering_gain_u_i1.
    localparam int MCC_BIT_I1_SIGN = 7;
    localparam int MCC_LSB_I1_EXP = 4;
    localparam int MCC_BIT_U_SIGN = 3;
    localparam int MCC_LSB_U_EXP = 0;

    // Field position of the quarter-gain bit in metering_control_third.
    localparam int MCC_BIT_QUARTER = 5;

    // Field positions of the status register.
    localparam int MCC_BIT_ST_STAGE = 0;
    localparam int MCC_BIT_ST_EMPTY = 1;
    localparam int MCC_BIT_ST_FULL = 2;
    localparam int MCC_BIT_ST_BLOCKED = 3;

    typedef struct packed {
        logic [MCC_SAMPLE_W-1:0] u;
        logic [MCC_SAMPLE_W-1:0] ia;
        logic [MCC_SAMPLE_W-1:0] ib;
        logic [MCC_SAMPLE_W-1:0] m;
    } mcc_raw_t;

    typedef struct packed {
        logic [MCC_OUT_W-1:0] u;
        logic [MCC_OUT_W-1:0] i1;
        logic [MCC_OUT_W-1:0] i2;
        logic [MCC_SAMPLE_W-1:0] m;
    } mcc_frame_t;

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] gain;
        logic quarter;
        logic [31:0] rdata;
        logic stg_valid;
        mcc_frame_t stg;
    } mcc_top_state_t;

endpackage

// ### core/mcc_top.sv
// Metering channel control: APB registers, channel gating, swap and gain, plus output FIFO.
// Assumes all reset sources of the chip are merged into presetn and samples arrive on pclk.
//
// Summary of operation
// - Every system reset clears all control bits.
// - Test bit blocks calculation writes to data.
// - Phase compensation enable bit drives correction.
// - Swap bit exchanges IA and IB channels.
// - Enable bit switches power, RMS, M processing.
// - M enable low feeds zero to M.
// - I2 enable low feeds zero samples.
// - I1 enable low feeds zero samples.
// - U enable low feeds zero samples.
// - I1 sign bit selects inverting gain.
// - I1 gain is two to exponent 0..5.
// - U sign bit selects inverting gain.
// - U gain is two to exponent 0..5.
// - Quarter bit reduces U gain by four.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module mcc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill state.
    output logic full,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("mcc_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW:0] count;
    } mcc_fifo_state_t;

    mcc_fifo_state_t st;
    mcc_fifo_state_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign full = (st.count == (PW+1)'(DEPTH));
    assign empty = (st.count == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[st.rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wptr = st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = st.rptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage has no reset; empty guards every read of a stale word.
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[st.wptr] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////

// Behaviour seen from software.
// Both control registers and the quarter bit clear on every reset of the chip.
// All reset sources are merged upstream, so one asynchronous clear serves them all.
// The enable and gain registers each hold eight bits in the low byte of their word.
// The upper bits of a written word are ignored.
// The upper bits of a read word always return zero.
// The third control register keeps only the quarter-gain bit in this block.
// Its other bits belong to neighbouring logic and read back as zero here.
// A status word reports the stage, the FIFO fill state and the test block bit.
// The status word is read only; writes to it are accepted and ignored.
// Addresses that map to no register answer with an error in the access phase.
// Misaligned addresses answer with an error as well.
// A refused write changes nothing; a refused read returns zero, but a misaligned one returns the register of its word.
//
// Bus timing.
// The slave never inserts wait states, so every access phase ends at once.
// Read data are captured at the setup edge and stand in the access phase.
// Read data stay unchanged until the next read setup.
// A write takes effect at the edge that closes its access phase.
// Back-to-back transfers are allowed without an idle cycle.
//
// Sample path.
// One set of four samples is taken at each edge with valid and ready high.
// The controls in force are those held in the registers just before that edge.
// A write that lands at the same edge affects only the following samples.
// The swap selects which converter feeds the first current channel.
// Input gating happens after the swap, so an enable follows the channel.
// The second current channel is only sign-extended here.
// Its own gain lives in a neighbouring register outside this block.
// The M channel also stays at zero while calculation is switched off.
//
// Gain.
// The exponent shifts left; exponents above the valid range clamp to the top.
// Clamping keeps the result inside the headroom bits for every input.
// The quarter option shifts right by two after the left shift.
// With small exponents the quarter option truncates towards minus infinity.
// That loses at most two low bits, below the noise of the converters.
// Negation comes last, so a sign bit never changes the magnitude.
// The most negative sample at the largest exponent still negates exactly.
//
// Latency and flow.
// A frame appears two edges after its sample is taken if the FIFO is free.
// One stage register sits ahead of the FIFO to break the gain path.
// The stage refuses a sample only when it is full and the FIFO is full.
// So the block holds the FIFO depth plus one frame before it pushes back.
// Frames leave in the order their samples came in.
// A frame stands unchanged until the consumer takes it.
//
// Calculation controls.
// The enables for compensation and calculation are plain register bits.
// Writes into the metering data need calculation on and the test block off.
// The test block is meant for production test and is off after reset.
// The gating of those writes is combinational, so it acts in the same cycle.
//
// Limitations.
// Samples are assumed to be produced on the bus clock already.
// No synchroniser stands in the sample path for that reason.
// A converter on another clock needs a clock-crossing FIFO in front.
// Parity and protection of the bus are not supported.

module mcc_top
    import mcc_pkg::*;
#(
    parameter int SAMPLE_W = MCC_SAMPLE_W,
    parameter int FIFO_DEPTH = MCC_FIFO_DEPTH
) (
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [MCC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Raw samples from the converters.
    input wire logic raw_valid,
    output logic raw_ready,
    input wire mcc_raw_t raw,
    // Processed samples towards the metering datapath.
    output logic frame_valid,
    input wire logic frame_ready,
    output mcc_frame_t frame,
    // Controls of the calculation and compensation circuits.
    output logic phase_comp_enable,
    output logic power_rms_calc_enable,
    output logic calc_data_write_block,
    input wire logic calc_wr_req,
    output logic meter_data_wr
);
    generate
        if (SAMPLE_W != MCC_SAMPLE_W) begin : g_bad
            $error("mcc_top: SAMPLE_W must match the package sample width");
        end
        if (FIFO_DEPTH < 2) begin : g_bad_depth
            $error("mcc_top: FIFO_DEPTH must be at least 2");
        end
    endgenerate

    function automatic logic [13:0] mcc_index(input logic [MCC_ADDR_W-1:0] a);
        return a[15:2];
    endfunction

    function automatic logic mcc_mapped(input logic [MCC_ADDR_W-1:0] a);
        logic [13:0] i;
        i = mcc_index(a);
        return (a[1:0] == 2'h0) && (i == MCC_IDX_ENABLE || i == MCC_IDX_GAIN ||
            i == MCC_IDX_CTRL3 || i == MCC_IDX_STATUS);
    endfunction

    // Shift first, then quarter, then negate; exact except that quarter drops low bits at exponents 0 and 1.
    function automatic logic [MCC_OUT_W-1:0] mcc_gain(
        input logic [MCC_SAMPLE_W-1:0] s,
        input logic [2:0] e,
        input logic neg,
        input logic quarter
    );
        logic signed [MCC_OUT_W-1:0] x;
        logic [2:0] ec;
        ec = (e > MCC_EXP_MAX) ? MCC_EXP_MAX : e;
        x = {{MCC_GAIN_HEAD{s[MCC_SAMPLE_W-1]}}, s};
        x = x <<< ec;
        if (quarter) begin
            x = x >>> MCC_QUARTER_SHIFT;
        end
        if (neg) begin
            x = -x;
        end
        return x;
    endfunction

    mcc_top_state_t st;
    mcc_top_state_t next_st;
    logic fifo_in_ready;
    logic fifo_full;
    logic fifo_empty;
    logic [MCC_SAMPLE_W-1:0] u_raw;
    logic [MCC_SAMPLE_W-1:0] i1_raw;
    logic [MCC_SAMPLE_W-1:0] i2_raw;
    logic [MCC_SAMPLE_W-1:0] m_raw;
    logic wr_en;
    logic rd_setup;
    logic [13:0] idx;

    // Bus decode is shared by the write path, the read path and the error flag.
    // The read is decoded in setup so that the data come from a flip-flop.

    ////////////////////////////////////////////////////////////////////////////

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mcc_mapped(paddr);
    assign prdata = st.rdata;
    assign idx = mcc_index(paddr);
    assign wr_en = psel && penable && pwrite && mcc_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    assign phase_comp_enable = st.enable[MCC_BIT_PHASE_COMP];
    assign power_rms_calc_enable = st.enable[MCC_BIT_CALC_EN];
    assign calc_data_write_block = st.enable[MCC_BIT_WRITE_BLOCK];
    // Writes need the calculation running and the test block released.
    assign meter_data_wr = calc_wr_req && power_rms_calc_enable && !calc_data_write_block;

    // Channel swap and input gating.
    assign i1_raw = st.enable[MCC_BIT_SWAP] ? raw.ib : raw.ia;
    assign i2_raw = st.enable[MCC_BIT_SWAP] ? raw.ia : raw.ib;
    assign u_raw = st.enable[MCC_BIT_U_EN] ? raw.u : '0;
    assign m_raw = st.enable[MCC_BIT_M_EN] ? raw.m : '0;

    // One stage ahead of the FIFO; it takes a sample when it is empty or when it can pass its own on.
    assign raw_ready = !st.stg_valid || fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////////

    // The stage empties into the FIFO and refills from the converters in one cycle.
    // Register writes come last so that a write never alters a sample in flight.
    always_comb begin
        next_st = st;
        if (st.stg_valid && fifo_in_ready) begin
            next_st.stg_valid = 1'b0;
        end
        if (raw_valid && raw_ready) begin
            next_st.stg_valid = 1'b1;
            next_st.stg.u = mcc_gain(u_raw, st.gain[MCC_LSB_U_EXP +: 3],
                st.gain[MCC_BIT_U_SIGN], st.quarter);
            next_st.stg.i1 = st.enable[MCC_BIT_I1_EN] ?
                mcc_gain(i1_raw, st.gain[MCC_LSB_I1_EXP +: 3],
                st.gain[MCC_BIT_I1_SIGN], 1'b0) : '0;
            next_st.stg.i2 = st.enable[MCC_BIT_I2_EN] ?
                {{MCC_GAIN_HEAD{i2_raw[MCC_SAMPLE_W-1]}}, i2_raw} : '0;
            // M samples only move while M processing runs.
            next_st.stg.m = st.enable[MCC_BIT_CALC_EN] ? m_raw : '0;
        end
        if (wr_en) begin
            case (idx)
                MCC_IDX_ENABLE: next_st.enable = pwdata[7:0];
                MCC_IDX_GAIN: next_st.gain = pwdata[7:0];
                MCC_IDX_CTRL3: next_st.quarter = pwdata[MCC_BIT_QUARTER];
                default: next_st.quarter = st.quarter;
            endcase
        end
        if (rd_setup) begin
            next_st.rdata = '0;
            case (idx)
                MCC_IDX_ENABLE: next_st.rdata[7:0] = st.enable;
                MCC_IDX_GAIN: next_st.rdata[7:0] = st.gain;
                MCC_IDX_CTRL3: next_st.rdata[MCC_BIT_QUARTER] = st.quarter;
                MCC_IDX_STATUS: begin
                    next_st.rdata[MCC_BIT_ST_STAGE] = st.stg_valid;
                    next_st.rdata[MCC_BIT_ST_EMPTY] = fifo_empty;
                    next_st.rdata[MCC_BIT_ST_FULL] = fifo_full;
                    next_st.rdata[MCC_BIT_ST_BLOCKED] = calc_data_write_block;
                end
                default: next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.enable <= MCC_ENABLE_RESET;
            st.gain <= MCC_GAIN_RESET;
            st.quarter <= MCC_QUARTER_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // The FIFO decouples the consumer from the converter rate.
    // Its depth is a parameter; the default keeps four frames.
    mcc_fifo #(
        .WIDTH($bits(mcc_frame_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(st.stg_valid),
        .in_ready(fifo_in_ready),
        .in_data(st.stg),
        .out_valid(frame_valid),
        .out_ready(frame_ready),
        .out_data(frame),
        .full(fifo_full),
        .empty(fifo_empty)
    );
endmodule

// ### verif/mcc_checker.sv
// Concurrent checks on the ports of the metering channel control block.
// Assumes the block runs on pclk alone with presetn as its only reset.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module mcc_checker import mcc_pkg::*; (
    // Clock, reset and bus.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [MCC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sample streams.
    input wire logic raw_valid,
    input wire logic raw_ready,
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire mcc_frame_t frame,
    // Calculation controls.
    input wire logic phase_comp_enable,
    input wire logic power_rms_calc_enable,
    input wire logic calc_data_write_block,
    input wire logic calc_wr_req,
    input wire logic meter_data_wr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire en_wr = psel && penable && pwrite && paddr == {MCC_IDX_ENABLE, 2'h0};

    a_reset_clear: assert property ($rose(presetn) |-> !phase_comp_enable
        && !power_rms_calc_enable && !calc_data_write_block && !frame_valid)
        else $error("controls not cleared by reset");
    a_wr_gate: assert property (meter_data_wr == (calc_wr_req
        && power_rms_calc_enable && !calc_data_write_block)) else $error("write gate wrong");
    a_block_write: assert property (en_wr |=> calc_data_write_block == $past(pwdata[7]))
        else $error("write block bit not taken");
    a_phase_write: assert property (en_wr |=> phase_comp_enable == $past(pwdata[6]))
        else $error("phase bit not taken");
    a_calc_write: assert property (en_wr |=> power_rms_calc_enable == $past(pwdata[4]))
        else $error("calc bit not taken");
    a_frame_hold: assert property (frame_valid && !frame_ready |=> frame_valid
        && $stable(frame)) else $error("frame changed while stalled");
    a_frame_latency: assert property (raw_valid && raw_ready |-> ##2 frame_valid)
        else $error("frame late");
    a_empty_ready: assert property (!frame_valid |-> raw_ready) else $error("refused when empty");
    a_bus_ready: assert property (psel && penable |-> pready) else $error("no ready");
    a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");

    c_refused: cover property (raw_valid && !raw_ready);
    c_drained: cover property (frame_valid && frame_ready);
    c_bus_err: cover property (psel && penable && pslverr);
endmodule

bind mcc_top mcc_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .raw_valid, .raw_ready, .frame_valid, .frame_ready, .frame,
    .phase_comp_enable, .power_rms_calc_enable, .calc_data_write_block, .calc_wr_req,
    .meter_data_wr);

// ### verif/tb_top.sv
// Self-checking bench for the metering channel control block.
// Assumes the package, the design and the checker are compiled before it.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module tb_top import mcc_pkg::*; ;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic raw_valid = 0, frame_ready = 0, calc_wr_req = 0, e;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, raw_ready, frame_valid, meter_data_wr;
    logic phase_comp_enable, power_rms_calc_enable, calc_data_write_block;
    mcc_raw_t raw = '0;
    mcc_frame_t frame, f;
    int err_count = 0, comparisons = 0;
    localparam logic [15:0] A_EN = {MCC_IDX_ENABLE, 2'h0};
    localparam logic [15:0] A_GN = {MCC_IDX_GAIN, 2'h0};
    localparam logic [15:0] A_C3 = {MCC_IDX_CTRL3, 2'h0};
    localparam mcc_raw_t SMP = '{24'h800123, 24'h012345, 24'hfe0001, 24'h00abcd};

    always #25 pclk = ~pclk;

    mcc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .raw_valid, .raw_ready, .raw, .frame_valid, .frame_ready, .frame,
        .phase_comp_enable, .power_rms_calc_enable, .calc_data_write_block, .calc_wr_req,
        .meter_data_wr);

    ////////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [113:0] s, input logic [113:0] x);
        comparisons++;
        if (s !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask

    // One idle edge closes every transfer, so calls may follow each other directly.
    task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task send(input mcc_raw_t r);
        raw <= r;
        raw_valid <= 1;
        do @(posedge pclk); while (raw_ready !== 1);
        raw_valid <= 0;
        raw <= ~r;
    endtask

    task recv();
        frame_ready <= 1;
        do @(posedge pclk); while (frame_valid !== 1);
        f = frame;
    endtask

    function automatic mcc_frame_t model(logic [7:0] n, logic [7:0] g, logic qt, mcc_raw_t r);
        logic signed [MCC_OUT_W-1:0] u, a, b;
        logic [2:0] eu, ei;
        eu = g[2:0] > MCC_EXP_MAX ? MCC_EXP_MAX : g[2:0];
        ei = g[6:4] > MCC_EXP_MAX ? MCC_EXP_MAX : g[6:4];
        u = $signed(r.u);
        u = u <<< eu;
        if (qt) u = u >>> MCC_QUARTER_SHIFT;
        if (g[3]) u = -u;
        a = $signed(n[5] ? r.ib : r.ia);
        a = a <<< ei;
        if (g[7]) a = -a;
        b = $signed(n[5] ? r.ia : r.ib);
        model.u = n[0] ? u : '0;
        model.i1 = n[1] ? a : '0;
        model.i2 = n[2] ? b : '0;
        model.m = n[3] && n[4] ? r.m : '0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task t_reset();
        bus(0, A_EN, 0);
        chk("enable reset", q, MCC_ENABLE_RESET);
        bus(0, A_GN, 0);
        chk("gain reset", q, MCC_GAIN_RESET);
        bus(1, A_EN, 32'hff);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk("calc after reset", power_rms_calc_enable, 0);
        bus(0, A_EN, 0);
        chk("enable mid reset", q, 0);
        bus(0, A_EN + 16'h1, 0);
        chk("misaligned err", e, 1);
    endtask

    task t_ctrl();
        logic [7:0] cv [4] = '{8'hd0, 8'h50, 8'h40, 8'h10};
        calc_wr_req <= 1;
        for (int i = 0; i < 4; i++) begin
            bus(1, A_EN, {24'h0, cv[i]});
            chk("phase", phase_comp_enable, cv[i][6]);
            chk("calc", power_rms_calc_enable, cv[i][4]);
            chk("block", calc_data_write_block, cv[i][7]);
            chk("data wr", meter_data_wr, cv[i][4] & ~cv[i][7]);
        end
        bus(1, A_GN, 32'hffffffff);
        bus(0, A_GN, 0);
        chk("gain width", q, 32'hff);
    endtask

    task t_gate();
        bus(1, A_GN, 0);
        for (int k = 0; k < 64; k++) begin
            bus(1, A_EN, 32'(k));
            send(SMP);
            recv();
            chk("gate", f, model(8'(k), 8'h0, 0, SMP));
        end
    endtask

    task t_gain();
        logic [7:0] g;
        bus(1, A_EN, 32'h1f);
        for (int k = 0; k < 32; k++) begin
            g = {~k[3], ~k[2:0], k[3], k[2:0]};
            bus(1, A_GN, {24'h0, g});
            bus(1, A_C3, {26'h0, k[4], 5'h0});
            send(SMP);
            recv();
            chk("gain", f, model(8'h1f, g, k[4], SMP));
        end
    endtask

    // Stage plus four FIFO words hold five samples; the sixth must wait.
    task t_fifo();
        bus(1, A_C3, 0);
        bus(1, A_GN, 0);
        frame_ready <= 0;
        raw_valid <= 1;
        for (int i = 1; i < 6; i++) begin
            raw <= {24'(i), SMP[71:0]};
            do @(posedge pclk); while (raw_ready !== 1);
        end
        raw <= {24'h6, SMP[71:0]};
        repeat (3) begin
            @(posedge pclk);
            chk("refused", raw_ready, 0);
        end
        // Draining frees a FIFO word, so the stage passes its frame on and the waiting sixth sample goes in meanwhile.
        frame_ready <= 1;
        for (int i = 1; i < 7; i++) begin
            do begin
                @(posedge pclk);
                if (raw_ready === 1) begin
                    raw_valid <= 0;
                end
            end while (frame_valid !== 1);
            chk("order", frame.u, 30'(i));
        end
        @(posedge pclk);
        chk("drained", frame_valid, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset();
        t_ctrl();
        t_gate();
        t_gain();
        t_fifo();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        final_report();
    end
endmodule
